// ### ccpcp_pkg.sv
// Package with register map, fields, modes and reset values for compare/PWM
// Notes on behaviour
// - Compare match register against wide timer once per increment
// - Match drives pin per mode, sets flag
// - Mode codes: off, set, clear, irq, event, PWM
// - Control write zero forces compare latch low
// - Interrupt-only mode leaves pin untouched
// - Special event trigger clears the wide timer
// - Special event trigger also starts conversion
// - Event clear never sets timer overflow flag
// - PWM output with ten-bit duty resolution
// - Control cleared forces PWM latch low
// - Period match clears timer, loads duty, sets pin unless the new duty is zero
// - Postscaler affects only timer interrupt rate
// - Duty is low register plus control bits 5:4
// - Duty double buffered, loaded at period end
// - Pin cleared when duty equals extended timer
// - Duty beyond period keeps output high
// - Prescaler divides by 1, 4 or 16
package ccpcp_pkg;
  localparam logic [7:0] CCPCP_OFS_CONTROL = 8'h00;
  localparam logic [7:0] CCPCP_OFS_DUTY_LOW = 8'h04;
  localparam logic [7:0] CCPCP_OFS_DUTY_HIGH = 8'h08;
  localparam logic [7:0] CCPCP_OFS_PERIOD = 8'h0C;
  localparam logic [7:0] CCPCP_OFS_TIMER_CTRL = 8'h10;
  localparam logic [7:0] CCPCP_OFS_PWM_COUNT = 8'h14;
  localparam logic [7:0] CCPCP_OFS_WIDE_COUNT = 8'h18;
  localparam logic [7:0] CCPCP_OFS_STATUS = 8'h1C;
  localparam logic [7:0] CCPCP_OFS_WIDE_CTRL = 8'h20;
  localparam int CCPCP_MODE_LSB = 0;
  localparam int CCPCP_DLOW_LSB = 4;
  localparam int CCPCP_TON_BIT = 2;
  localparam int CCPCP_POST_LSB = 3;
  localparam int CCPCP_ST_CHAN = 0;
  localparam int CCPCP_ST_WOVF = 1;
  localparam int CCPCP_ST_PWMT = 2;
  localparam logic [7:0] CCPCP_RST_PERIOD = 8'hFF;
  localparam logic [5:0] CCPCP_RST_CONTROL = 6'h00;
  localparam logic [6:0] CCPCP_RST_TIMER_CTRL = 7'h00;
  localparam logic [1:0] CCPCP_QUARTER_LAST = 2'h3;
  localparam logic [3:0] CCPCP_PRE16_LAST = 4'hF;
  localparam logic [3:0] CCPCP_PRE4_LAST = 4'h3;
  typedef enum logic [3:0] {
    CCPCP_M_OFF = 4'b0000,
    CCPCP_M_SET = 4'b1000,
    CCPCP_M_CLR = 4'b1001,
    CCPCP_M_IRQ = 4'b1010,
    CCPCP_M_EVT = 4'b1011
  } ccpcp_mode_t;
endpackage

// ### ccpcp_prescale.sv
// Prescaler and quarter-cycle counter for the PWM timer
`timescale 1ns/1ps
`default_nettype none
module ccpcp_prescale
  import ccpcp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [1:0] ratio_sel,
  output logic tick,
  output logic [1:0] sub_count
);
  logic [1:0] quarter_r;
  logic [3:0] pre_r;
  logic quarter_end;
  logic pre_end;
  assign quarter_end = (quarter_r == CCPCP_QUARTER_LAST);
  always_comb begin
    unique case (ratio_sel)
      2'h0: pre_end = 1'b1;
      2'h1: pre_end = (pre_r == CCPCP_PRE4_LAST);
      default: pre_end = (pre_r == CCPCP_PRE16_LAST);
    endcase
  end
  // Four clocks per instruction cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quarter_r <= 2'h0;
    end else begin
      quarter_r <= quarter_r + 2'h1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_r <= 4'h0;
    end else if (!run) begin
      pre_r <= 4'h0;
    end else if (quarter_end) begin
      pre_r <= pre_end ? 4'h0 : pre_r + 4'h1;
    end
  end
  assign tick = run && quarter_end && pre_end;
  // Low two bits of the ten-bit time base
  always_comb begin
    unique case (ratio_sel)
      2'h0: sub_count = quarter_r;
      2'h1: sub_count = pre_r[1:0];
      default: sub_count = pre_r[3:2];
    endcase
  end
endmodule
`default_nettype wire

// ### ccpcp_top.sv
// Compare and PWM channel with APB register access
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ccpcp_top
  import ccpcp_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic CHANNEL_PIN,
  output logic CONVERT_START
);
  logic [5:0] channel_control_r;
  logic [7:0] match_duty_low_r;
  logic [7:0] match_duty_high_r;
  logic [7:0] pwm_period_register_r;
  logic [6:0] pwm_timer_control_r;
  logic [7:0] pwm_timer_count_r;
  logic [15:0] wide_timer_count_r;
  logic wide_run_r;
  logic [1:0] duty_latch_r;
  logic compare_latch_r;
  logic pwm_latch_r;
  logic pin_r;
  logic convert_r;
  logic channel_irq_flag_r;
  logic wide_timer_overflow_flag_r;
  logic pwm_timer_flag_r;
  logic [3:0] post_r;
  logic [31:0] prdata_r;
  logic wide_tick_r;
  logic [1:0] wide_div_r;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [3:0] mode;
  logic pwm_mode;
  logic cmp_mode;
  logic match;
  logic special_evt;
  logic period_hit;
  logic pwm_tick;
  logic [1:0] sub_count;
  logic [9:0] duty_buf;
  logic duty_zero;
  logic pwm_clear;
  logic [31:0] rd_mux;

  function automatic logic wsel(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;
  assign mode = channel_control_r[3:0];
  assign pwm_mode = (mode[3:2] == 2'b11);
  assign cmp_mode = (mode[3:2] == 2'b10);
  assign duty_buf = {match_duty_high_r, duty_latch_r};
  assign duty_zero = ({match_duty_low_r, channel_control_r[5:4]} == 10'h000);
  // Duty reached: pin low from the matching quarter-cycle on
  assign pwm_clear = pwm_mode && pwm_timer_control_r[CCPCP_TON_BIT] &&
    (duty_buf == {pwm_timer_count_r, sub_count});

  ccpcp_prescale u_pre (
    .clk(CLOCK),
    .rst(SYS_RST),
    .run(pwm_timer_control_r[CCPCP_TON_BIT]),
    .ratio_sel(pwm_timer_control_r[1:0]),
    .tick(pwm_tick),
    .sub_count(sub_count)
  );

  // Wide timer advances once per instruction cycle
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wide_div_r <= 2'h0;
      wide_tick_r <= 1'b0;
    end else begin
      wide_div_r <= wide_div_r + 2'h1;
      wide_tick_r <= wide_run_r && (wide_div_r == CCPCP_QUARTER_LAST);
    end
  end

  // Match tested once per increment
  assign match = cmp_mode && wide_tick_r &&
    (wide_timer_count_r == {match_duty_high_r, match_duty_low_r});
  assign special_evt = match && (mode == CCPCP_M_EVT);
  assign period_hit = pwm_tick && (pwm_timer_count_r == pwm_period_register_r);

  // Address decode
  always_comb begin
    addr_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    if (wsel(PADDR, CCPCP_OFS_CONTROL)) begin
      rd_mux[5:0] = channel_control_r;
    end else if (wsel(PADDR, CCPCP_OFS_DUTY_LOW)) begin
      rd_mux[7:0] = match_duty_low_r;
    end else if (wsel(PADDR, CCPCP_OFS_DUTY_HIGH)) begin
      rd_mux[7:0] = match_duty_high_r;
    end else if (wsel(PADDR, CCPCP_OFS_PERIOD)) begin
      rd_mux[7:0] = pwm_period_register_r;
    end else if (wsel(PADDR, CCPCP_OFS_TIMER_CTRL)) begin
      rd_mux[6:0] = pwm_timer_control_r;
    end else if (wsel(PADDR, CCPCP_OFS_PWM_COUNT)) begin
      rd_mux[7:0] = pwm_timer_count_r;
    end else if (wsel(PADDR, CCPCP_OFS_WIDE_COUNT)) begin
      rd_mux[15:0] = wide_timer_count_r;
    end else if (wsel(PADDR, CCPCP_OFS_STATUS)) begin
      rd_mux[CCPCP_ST_CHAN] = channel_irq_flag_r;
      rd_mux[CCPCP_ST_WOVF] = wide_timer_overflow_flag_r;
      rd_mux[CCPCP_ST_PWMT] = pwm_timer_flag_r;
      rd_mux[3] = CHANNEL_PIN;
    end else if (wsel(PADDR, CCPCP_OFS_WIDE_CTRL)) begin
      rd_mux[0] = wide_run_r;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // Zero wait-state APB answer
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !addr_ok;
      if (PSEL && !PENABLE && !PWRITE) begin
        prdata_r <= rd_mux;
      end
    end
  end
  assign PRDATA = prdata_r;

  logic acc;
  assign acc = PREADY;

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      channel_control_r <= CCPCP_RST_CONTROL;
    end else if (acc && wr_en && wsel(PADDR, CCPCP_OFS_CONTROL)) begin
      channel_control_r <= PWDATA[5:0];
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      match_duty_low_r <= 8'h00;
    end else if (acc && wr_en && wsel(PADDR, CCPCP_OFS_DUTY_LOW)) begin
      match_duty_low_r <= PWDATA[7:0];
    end
  end

  // High byte is read-only in PWM mode
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      match_duty_high_r <= 8'h00;
      duty_latch_r <= 2'h0;
    end else if (pwm_mode) begin
      if (period_hit) begin
        match_duty_high_r <= match_duty_low_r;
        duty_latch_r <= channel_control_r[5:4];
      end
    end else if (acc && wr_en && wsel(PADDR, CCPCP_OFS_DUTY_HIGH)) begin
      match_duty_high_r <= PWDATA[7:0];
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pwm_period_register_r <= CCPCP_RST_PERIOD;
    end else if (acc && wr_en && wsel(PADDR, CCPCP_OFS_PERIOD)) begin
      pwm_period_register_r <= PWDATA[7:0];
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pwm_timer_control_r <= CCPCP_RST_TIMER_CTRL;
    end else if (acc && wr_en && wsel(PADDR, CCPCP_OFS_TIMER_CTRL)) begin
      pwm_timer_control_r <= PWDATA[6:0];
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wide_run_r <= 1'b0;
    end else if (acc && wr_en && wsel(PADDR, CCPCP_OFS_WIDE_CTRL)) begin
      wide_run_r <= PWDATA[0];
    end
  end

  // Wide timer; event clear skips overflow flag
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wide_timer_count_r <= 16'h0000;
    end else if (acc && wr_en && wsel(PADDR, CCPCP_OFS_WIDE_COUNT)) begin
      wide_timer_count_r <= PWDATA[15:0];
    end else if (special_evt) begin
      wide_timer_count_r <= 16'h0000;
    end else if (wide_tick_r) begin
      wide_timer_count_r <= wide_timer_count_r + 16'h0001;
    end
  end

  // PWM timer
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pwm_timer_count_r <= 8'h00;
    end else if (acc && wr_en && wsel(PADDR, CCPCP_OFS_PWM_COUNT)) begin
      pwm_timer_count_r <= PWDATA[7:0];
    end else if (period_hit) begin
      pwm_timer_count_r <= 8'h00;
    end else if (pwm_tick) begin
      pwm_timer_count_r <= pwm_timer_count_r + 8'h01;
    end
  end

  // Postscaler drives only the timer flag
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      post_r <= 4'h0;
    end else if (period_hit) begin
      post_r <= (post_r == pwm_timer_control_r[6:3]) ? 4'h0 :
        post_r + 4'h1;
    end
  end

  // Sticky flags: set wins over clear
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      channel_irq_flag_r <= 1'b0;
      wide_timer_overflow_flag_r <= 1'b0;
      pwm_timer_flag_r <= 1'b0;
    end else begin
      if (match) begin
        channel_irq_flag_r <= 1'b1;
      end else if (acc && wr_en && wsel(PADDR, CCPCP_OFS_STATUS) &&
                   PWDATA[CCPCP_ST_CHAN]) begin
        channel_irq_flag_r <= 1'b0;
      end
      if (wide_tick_r && !special_evt && (&wide_timer_count_r)) begin
        wide_timer_overflow_flag_r <= 1'b1;
      end else if (acc && wr_en && wsel(PADDR, CCPCP_OFS_STATUS) &&
                   PWDATA[CCPCP_ST_WOVF]) begin
        wide_timer_overflow_flag_r <= 1'b0;
      end
      if (period_hit && (post_r == pwm_timer_control_r[6:3])) begin
        pwm_timer_flag_r <= 1'b1;
      end else if (acc && wr_en && wsel(PADDR, CCPCP_OFS_STATUS) &&
                   PWDATA[CCPCP_ST_PWMT]) begin
        pwm_timer_flag_r <= 1'b0;
      end
    end
  end

  // Compare output latch
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      compare_latch_r <= 1'b0;
    end else if (mode == CCPCP_M_OFF) begin
      compare_latch_r <= 1'b0;
    end else if (match && mode == CCPCP_M_SET) begin
      compare_latch_r <= 1'b1;
    end else if (match && mode == CCPCP_M_CLR) begin
      compare_latch_r <= 1'b0;
    end
  end

  // PWM output latch
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pwm_latch_r <= 1'b0;
    end else if (mode == CCPCP_M_OFF) begin
      pwm_latch_r <= 1'b0;
    end else if (pwm_mode && period_hit) begin
      pwm_latch_r <= !duty_zero;
    end else if (pwm_clear) begin
      pwm_latch_r <= 1'b0;
    end
  end

  // Pin and conversion trigger
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pin_r <= 1'b0;
      convert_r <= 1'b0;
    end else begin
      // Clear masks the latch so the high time is not one clock longer
      pin_r <= pwm_mode ? (pwm_latch_r && !pwm_clear) : compare_latch_r;
      convert_r <= special_evt;
    end
  end
  assign CHANNEL_PIN = pin_r;
  assign CONVERT_START = convert_r;
endmodule
`default_nettype wire

// ### ccpcp_chk.sv
// Port checker for the compare and PWM channel
`timescale 1ns/1ps
`default_nettype none
module ccpcp_chk
  import ccpcp_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic CHANNEL_PIN,
  input wire logic CONVERT_START
);
  logic [3:0] mode_r;
  logic [2:0] age_r;
  logic acc;
  logic cw;
  logic ok;
  assign acc = PSEL && PENABLE && PREADY;
  assign cw = acc && PWRITE && PADDR == CCPCP_OFS_CONTROL;
  assign ok = age_r == 3'h7;
  // Last mode written, cycles since
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode_r <= 4'h0;
      age_r <= 3'h7;
    end else if (cw) begin
      mode_r <= PWDATA[3:0];
      age_r <= 3'h0;
    end else if (!ok) begin
      age_r <= age_r + 3'h1;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  AST_OFF_LOW: assert property (
    ok && mode_r == CCPCP_M_OFF |-> !CHANNEL_PIN)
    else $error("Pin high while off");
  AST_ZERO_LOW: assert property (
    cw && PWDATA[5:0] == 6'h00 |-> ##[1:3] !CHANNEL_PIN)
    else $error("Pin not low after control cleared");
  AST_SET_KEEP: assert property (
    ok && mode_r == CCPCP_M_SET |-> !$fell(CHANNEL_PIN))
    else $error("Pin fell in set mode");
  AST_CLR_KEEP: assert property (
    ok && mode_r == CCPCP_M_CLR |-> !$rose(CHANNEL_PIN))
    else $error("Pin rose in clear mode");
  AST_IRQ_KEEP: assert property (
    ok && mode_r == CCPCP_M_IRQ |-> $stable(CHANNEL_PIN))
    else $error("Pin moved in interrupt mode");
  AST_EVT_SRC: assert property (
    CONVERT_START |-> mode_r == CCPCP_M_EVT || age_r < 3'h4)
    else $error("Convert start outside event mode");
  AST_EVT_GAP: assert property (
    CONVERT_START |=> !CONVERT_START [*3])
    else $error("Convert start pulses too close");
  AST_NO_OVF: assert property (
    acc && !PWRITE && PADDR == CCPCP_OFS_STATUS |-> !PRDATA[1])
    else $error("Overflow flag set");
endmodule
bind ccpcp_top ccpcp_chk u_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .CHANNEL_PIN(CHANNEL_PIN), .CONVERT_START(CONVERT_START));
`default_nettype wire

// ### ccpcp_load.sv
// Load on the channel pin, measuring high time and period
`timescale 1ns/1ps
`default_nettype none
module ccpcp_load (
  input wire logic clk,
  input wire logic pin,
  output var int high_len,
  output var int per_len
);
  int hc = 0;
  int pc = 0;
  logic pin_d = 1'h0;
  // Pin only sensed, never driven back
  always_ff @(posedge clk) begin
    pin_d <= pin;
    if (pin && !pin_d) begin
      per_len <= pc;
      pc <= 1;
      hc <= 1;
    end else begin
      pc <= pc + 1;
      hc <= hc + int'(pin);
    end
    if (!pin && pin_d) begin
      high_len <= hc;
    end
  end
endmodule
`default_nettype wire

// ### tb_top.sv
// Testbench for the compare and PWM channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  num_errors++; $display("Error %s exp %0h got %0h", n, e, g); end end
module tb_top
  import ccpcp_pkg::*;
;
  logic CLOCK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic CHANNEL_PIN, CONVERT_START, er;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  int num_errors = 0, samples_checked = 0, cyc = 0, g, c, high_len, per_len;
  ccpcp_mode_t cm [5] = '{CCPCP_M_SET, CCPCP_M_IRQ, CCPCP_M_OFF,
    CCPCP_M_SET, CCPCP_M_CLR};
  logic cp [5] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0};
  ccpcp_top dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CHANNEL_PIN(CHANNEL_PIN), .CONVERT_START(CONVERT_START));
  ccpcp_load u_load (.clk(CLOCK), .pin(CHANNEL_PIN),
    .high_len(high_len), .per_len(per_len));
  initial begin
    CLOCK = 1'h0;
    forever #12.5 CLOCK = ~CLOCK;
  end
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge CLOCK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'h1;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'h1 && n < 50);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask
  task automatic rdck(input string n, input logic [7:0] a,
    input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    `CHK(n, e, rd)
  endtask
  task automatic wait_cs(output int n);
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (CONVERT_START !== 1'h1 && n < 200);
  endtask
  task automatic count_pin(input logic lvl, output int n);
    n = 0;
    repeat (600) begin
      @(posedge CLOCK);
      n += int'(CHANNEL_PIN === lvl);
    end
  endtask
  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    SYS_RST = 1'h1;
    repeat (3) @(posedge CLOCK);
    SYS_RST <= 1'h0;
    rdck("period", CCPCP_OFS_PERIOD, 32'hFF);
    rdck("control", CCPCP_OFS_CONTROL, 32'h0);
    rdck("unmapped", 8'h40, 32'h0);
    `CHK("slverr", 1'h1, er)
    $display("Test reset done");
    wr(CCPCP_OFS_WIDE_CTRL, 32'h1);
    foreach (cm[i]) begin
      wr(CCPCP_OFS_CONTROL, {28'h0, cm[i]});
      wr(CCPCP_OFS_DUTY_LOW, 32'h10);
      wr(CCPCP_OFS_DUTY_HIGH, 32'h0);
      wr(CCPCP_OFS_STATUS, 32'h1);
      wr(CCPCP_OFS_WIDE_COUNT, 32'h0);
      repeat (100) @(posedge CLOCK);
      `CHK("cmp pin", cp[i], CHANNEL_PIN)
      xfer(1'h0, CCPCP_OFS_STATUS, 32'h0);
      `CHK("cmp flag", cm[i] != CCPCP_M_OFF, rd[0])
    end
    $display("Test compare done");
    wr(CCPCP_OFS_CONTROL, {28'h0, CCPCP_M_EVT});
    wr(CCPCP_OFS_DUTY_LOW, 32'h8);
    wr(CCPCP_OFS_DUTY_HIGH, 32'h0);
    wr(CCPCP_OFS_STATUS, 32'h3);
    wr(CCPCP_OFS_WIDE_COUNT, 32'h0);
    wait_cs(g);
    wait_cs(g);
    `CHK("event gap", 36, g)
    xfer(1'h0, CCPCP_OFS_WIDE_COUNT, 32'h0);
    `CHK("wide count", 1'h1, rd < 32'h9)
    xfer(1'h0, CCPCP_OFS_STATUS, 32'h0);
    `CHK("ovf flag", 1'h0, rd[1])
    $display("Test event done");
    for (int p = 0; p < 3; p++) begin
      wr(CCPCP_OFS_CONTROL, 32'h0);
      repeat (3) @(posedge CLOCK);
      `CHK("off pin", 1'h0, CHANNEL_PIN)
      wr(CCPCP_OFS_PERIOD, 32'h7);
      wr(CCPCP_OFS_DUTY_LOW, 32'h3);
      wr(CCPCP_OFS_TIMER_CTRL, 32'h4 | p);
      wr(CCPCP_OFS_CONTROL, 32'h2C);
      repeat (128 << (2 * p)) @(posedge CLOCK);
      `CHK("pwm period", 32 << (2 * p), per_len)
      `CHK("pwm high", 14 << (2 * p), high_len)
    end
    wr(CCPCP_OFS_DUTY_HIGH, 32'h55);
    rdck("duty high", CCPCP_OFS_DUTY_HIGH, 32'h3);
    wr(CCPCP_OFS_DUTY_LOW, 32'hFF);
    repeat (1100) @(posedge CLOCK);
    count_pin(1'h0, c);
    `CHK("full duty lows", 0, c)
    wr(CCPCP_OFS_DUTY_LOW, 32'h0);
    wr(CCPCP_OFS_CONTROL, 32'h0C);
    repeat (1100) @(posedge CLOCK);
    count_pin(1'h1, c);
    `CHK("zero duty highs", 0, c)
    $display("Test pwm done");
    wrap_up();
  end
endmodule
`default_nettype wire
